/* File: hw/acs_defines.svh */
// Purpose: Named offsets, field positions, lengths and sample-and-hold counts
// Assumes: APB byte addresses, 32-bit data
// Notes: Included by the sequencer and prescaler
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// Register byte offsets
`define ACS_OFF_INSEL 8'h00
`define ACS_OFF_CTLA 8'h04
`define ACS_OFF_CTLB 8'h08
`define ACS_OFF_RESLO 8'h0c
`define ACS_OFF_RESHI 8'h10
// Input select fields
`define ACS_INSEL_CHAN 5:0
`define ACS_INSEL_REF 7:6
`define ACS_INSEL_LEFT 8
`define ACS_CHAN_DIFF 5
// Control A fields
`define ACS_CTLA_PSEL 2:0
`define ACS_CTLA_FLAG 4
`define ACS_CTLA_AUTO 5
`define ACS_CTLA_START 6
`define ACS_CTLA_EN 7
// Control B fields
`define ACS_CTLB_TRIG 2:0
`define ACS_TRIG_FREE 3'h0
// Conversion lengths in converter clocks
`define ACS_LEN_NORMAL 5'h0d
`define ACS_LEN_FIRST 5'h19
`define ACS_LEN_DIFF 5'h0e
// Sample-and-hold points, in converter clocks, taken on falling edge
`define ACS_SH_NORMAL 5'h01
`define ACS_SH_FIRST 5'h0d
`define ACS_SH_DIFF 5'h02
// Auto trigger: hold on rising edge, end on falling edge
`define ACS_SH_AUTO 5'h01
`define ACS_END_AUTO 5'h0d
`define ACS_ONE5 5'h01
`endif

/* File: hw/acs_pkg.sv */
// Purpose: Shared types of the conversion sequencer
// Assumes: Nothing beyond the defines header
// Notes: Constants live in acs_defines.svh
package acs_pkg;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_CONV = 3'h4
   } acs_state_type;
endpackage

/* File: hw/acs_clk_if.sv */
// Purpose: Link between sequencer and converter clock prescaler
// Assumes: Single CPU clock domain
// Notes: Ticks are one-cycle pulses on the CPU clock
`timescale 1ns/10ps
interface acs_clk_if;
   logic enable;
   logic restart;
   logic [2:0] select;
   logic riseTick;
   logic fallTick;
   logic halfRate;
   modport presc (input enable, input restart, input select,
      output riseTick, output fallTick, output halfRate);
   modport seq (output enable, output restart, output select,
      input riseTick, input fallTick, input halfRate);
endinterface

/* File: hw/acs_prescaler.sv */
// Purpose: Converter clock prescaler, ratio 2 to 128 by power of two
// Assumes: Enable and restart come from the sequencer on clk
// Notes: Converter clock exists only as tick pulses
`timescale 1ns/10ps
`include "acs_defines.svh"
module acs_prescaler (
   input wire logic clk, // CPU clock
   input wire logic reset_n, // Async reset, active low
   acs_clk_if.presc ck // Tick link to the sequencer
);
   typedef struct packed {
      logic [6:0] count;
      logic half;
   } acs_presc_type;
   acs_presc_type cur_r;
   acs_presc_type cur_nxt;
   logic [6:0] ratioM1;
   logic [6:0] halfM1;
   assign ratioM1 = 7'((8'h02 << ck.select) - 8'h01);
   assign halfM1 = 7'(ratioM1 >> 1);
   // Ticks are combinational so the sequencer sees them in the same cycle
   assign ck.riseTick = ck.enable && !ck.restart && (cur_r.count == ratioM1);
   assign ck.fallTick = ck.enable && !ck.restart && (cur_r.count == halfM1);
   assign ck.halfRate = cur_r.half;
   always_comb
   begin
      cur_nxt = cur_r;
      if (!ck.enable || ck.restart)
      begin
         cur_nxt.count = 7'h00;
         cur_nxt.half = 1'b0;
      end
      else if (cur_r.count == ratioM1)
      begin
         cur_nxt.count = 7'h00;
         cur_nxt.half = !cur_r.half;
      end
      else
      begin
         cur_nxt.count = cur_r.count + 7'h01;
      end
   end
   // State register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cur_r <= '0;
      else
         cur_r <= cur_nxt;
   end
endmodule

/* File: hw/acs_sequencer.sv */
// Purpose: Conversion sequencer for a 10-bit successive-approximation converter
// Assumes: APB slave, zero wait states; analog core result settles before completion
// Notes: Converter clock is derived by acs_prescaler from clk
`timescale 1ns/10ps
`include "acs_defines.svh"
module acs_sequencer #(
   parameter int TRIG_WIDTH = 8 // Number of trigger source inputs
) (
   input wire logic clk, // CPU clock, 250 MHz
   input wire logic reset_n, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [TRIG_WIDTH-1:0] trigIn, // Trigger source levels
   input wire logic [9:0] coreResult, // Analog core result
   output logic coreEnable, // Analog enable
   output logic [5:0] coreChannel, // Applied channel
   output logic [1:0] coreReference, // Applied reference
   output logic sampleHold, // Sample-and-hold pulse
   output logic convDone, // Completion pulse
   output logic completeFlag // Conversion complete flag level
);
   typedef struct packed {
      acs_pkg::acs_state_type state;
      logic enable;
      logic start;
      logic autoEn;
      logic flag;
      logic [2:0] prescSel;
      logic [2:0] trigSel;
      logic [5:0] chan;
      logic [1:0] refSel;
      logic left;
      logic [5:0] holdChan;
      logic [1:0] holdRef;
      logic [9:0] result;
      logic locked;
      logic first;
      logic autoMode;
      logic [4:0] cnt;
      logic [4:0] endCnt;
      logic [4:0] shCnt;
      logic shOnRise;
      logic [31:0] rdata;
      logic [TRIG_WIDTH-1:0] trigMeta;
      logic [TRIG_WIDTH-1:0] trigSync;
      logic trigPrev;
      logic [9:0] resMeta;
      logic [9:0] resSync;
      logic shPulse;
      logic donePulse;
      logic restart;
   } acs_seq_type;
   acs_seq_type cur_r;
   acs_seq_type cur_nxt;
   acs_clk_if ck ();
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic trigLevel;
   logic trigEdge;
   logic busy;
   logic lastCycle;
   logic finish;
   logic freeRun;
   // Converter clock source
   acs_prescaler u_presc (
      .clk(clk),
      .reset_n(reset_n),
      .ck(ck)
   );
   assign ck.enable = cur_r.enable;
   assign ck.restart = cur_r.restart;
   assign ck.select = cur_r.prescSel;
   // APB decode; no wait states
   assign mapped = (paddr == `ACS_OFF_INSEL) || (paddr == `ACS_OFF_CTLA) ||
      (paddr == `ACS_OFF_CTLB) || (paddr == `ACS_OFF_RESLO) || (paddr == `ACS_OFF_RESHI);
   assign wrEn = psel && penable && pwrite && mapped;
   assign rdEn = psel && penable && !pwrite && mapped;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;
   assign prdata = cur_r.rdata;
   // Selected trigger, read only from the second synchroniser stage
   assign trigLevel = cur_r.trigSync[cur_r.trigSel];
   assign trigEdge = trigLevel && !cur_r.trigPrev;
   assign busy = (cur_r.state == acs_pkg::ST_CONV);
   assign freeRun = cur_r.autoEn && (cur_r.trigSel == `ACS_TRIG_FREE);
   // final converter clock of a conversion
   assign lastCycle = busy && (cur_r.cnt == cur_r.endCnt);
   assign finish = lastCycle && (cur_r.autoMode ? ck.fallTick : ck.riseTick);
   assign coreEnable = cur_r.enable;
   assign coreChannel = cur_r.enable ? cur_r.holdChan : 6'h00;
   assign coreReference = cur_r.enable ? cur_r.holdRef : 2'h0;
   assign sampleHold = cur_r.shPulse;
   assign convDone = cur_r.donePulse;
   assign completeFlag = cur_r.flag;
   // Next-state logic for registers, sequencing and bus
   always_comb
   begin
      cur_nxt = cur_r;
      cur_nxt.trigMeta = trigIn;
      cur_nxt.trigSync = cur_r.trigMeta;
      cur_nxt.trigPrev = trigLevel;
      cur_nxt.resMeta = coreResult;
      cur_nxt.resSync = cur_r.resMeta;
      cur_nxt.shPulse = 1'b0;
      cur_nxt.donePulse = 1'b0;
      cur_nxt.restart = 1'b0;
      // Register writes
      if (wrEn)
      begin
         unique case (paddr)
            `ACS_OFF_INSEL:
            begin
               cur_nxt.chan = pwdata[`ACS_INSEL_CHAN];
               cur_nxt.refSel = pwdata[`ACS_INSEL_REF];
               cur_nxt.left = pwdata[`ACS_INSEL_LEFT];
            end
            `ACS_OFF_CTLA:
            begin
               cur_nxt.enable = pwdata[`ACS_CTLA_EN];
               cur_nxt.autoEn = pwdata[`ACS_CTLA_AUTO];
               cur_nxt.prescSel = pwdata[`ACS_CTLA_PSEL];
               // Write one clears the flag
               if (pwdata[`ACS_CTLA_FLAG])
                  cur_nxt.flag = 1'b0;
               // next conversion after enabling is a long one
               if (pwdata[`ACS_CTLA_EN] && !cur_r.enable)
                  cur_nxt.first = 1'b1;
               // start request, also in auto mode; ignored if busy
               if (pwdata[`ACS_CTLA_START] && pwdata[`ACS_CTLA_EN] &&
                  cur_r.state == acs_pkg::ST_IDLE)
               begin
                  cur_nxt.start = 1'b1;
                  cur_nxt.state = acs_pkg::ST_WAIT;
               end
            end
            `ACS_OFF_CTLB:
               cur_nxt.trigSel = pwdata[`ACS_CTLB_TRIG];
            default:
               cur_nxt.first = cur_nxt.first;
         endcase
      end
      // Read data captured in the setup phase
      if (psel && !penable && !pwrite)
      begin
         cur_nxt.rdata = 32'h00000000;
         unique case (paddr)
            `ACS_OFF_INSEL:
               cur_nxt.rdata = {23'h000000, cur_r.left, cur_r.refSel, cur_r.chan};
            `ACS_OFF_CTLA:
               cur_nxt.rdata = {24'h000000, cur_r.enable, cur_r.start, cur_r.autoEn,
                  cur_r.flag, 1'b0, cur_r.prescSel};
            `ACS_OFF_CTLB:
               cur_nxt.rdata = {29'h00000000, cur_r.trigSel};
            `ACS_OFF_RESLO:
               cur_nxt.rdata = {24'h000000, cur_r.left ? {cur_r.result[1:0], 6'h00} :
                  cur_r.result[7:0]};
            `ACS_OFF_RESHI:
               cur_nxt.rdata = {24'h000000, cur_r.left ? cur_r.result[9:2] :
                  {6'h00, cur_r.result[9:8]}};
            default:
               cur_nxt.rdata = 32'h00000000;
         endcase
      end
      if (rdEn && paddr == `ACS_OFF_RESLO)
         cur_nxt.locked = 1'b1;
      if (rdEn && paddr == `ACS_OFF_RESHI)
         cur_nxt.locked = 1'b0;
      if (!busy || lastCycle)
      begin
         cur_nxt.holdChan = cur_nxt.chan;
         cur_nxt.holdRef = cur_nxt.refSel;
      end
      // Sequencer
      unique case (cur_r.state)
         acs_pkg::ST_IDLE:
         begin
            // edge only while idle restarts prescaler
            if (cur_r.enable && cur_r.autoEn && !freeRun && trigEdge &&
               cur_nxt.state == acs_pkg::ST_IDLE)
            begin
               cur_nxt.restart = 1'b1;
               cur_nxt.autoMode = !cur_r.first;
               cur_nxt.start = 1'b1;
               cur_nxt.state = acs_pkg::ST_WAIT;
            end
         end
         acs_pkg::ST_WAIT:
         begin
            // conversion begins on a converter clock rising edge
            if (ck.riseTick)
            begin
               cur_nxt.state = acs_pkg::ST_CONV;
               cur_nxt.cnt = 5'h00;
               cur_nxt.shOnRise = 1'b0;
               cur_nxt.endCnt = 5'(`ACS_LEN_NORMAL - 5'h01);
               cur_nxt.shCnt = `ACS_SH_NORMAL;
               if (cur_r.first)
               begin
                  cur_nxt.endCnt = 5'(`ACS_LEN_FIRST - 5'h01);
                  cur_nxt.shCnt = `ACS_SH_FIRST;
                  cur_nxt.first = 1'b0;
                  cur_nxt.autoMode = 1'b0;
               end
               else if (cur_r.autoMode)
               begin
                  // hold 2 clocks after trigger, end at 13.5
                  cur_nxt.endCnt = `ACS_END_AUTO;
                  cur_nxt.shCnt = `ACS_SH_AUTO;
                  cur_nxt.shOnRise = 1'b1;
               end
               else if (cur_r.chan[`ACS_CHAN_DIFF] && ck.halfRate)
               begin
                  // user start with half-rate clock high
                  cur_nxt.endCnt = 5'(`ACS_LEN_DIFF - 5'h01);
                  cur_nxt.shCnt = `ACS_SH_DIFF;
               end
            end
         end
         acs_pkg::ST_CONV:
         begin
            if (ck.riseTick && !lastCycle)
               cur_nxt.cnt = cur_r.cnt + 5'h01;
            if (cur_r.cnt == cur_r.shCnt && (cur_r.shOnRise ? ck.riseTick : ck.fallTick))
               cur_nxt.shPulse = 1'b1;
            if (finish)
            begin
               cur_nxt.donePulse = 1'b1;
               // flag sets always, even when result is dropped
               cur_nxt.flag = 1'b1;
               if (!cur_nxt.locked)
                  cur_nxt.result = cur_r.resSync;
               // free running restarts at once, start held
               if (freeRun)
               begin
                  cur_nxt.cnt = 5'h00;
                  cur_nxt.autoMode = 1'b0;
                  cur_nxt.shOnRise = 1'b0;
                  cur_nxt.endCnt = cur_r.chan[`ACS_CHAN_DIFF] ?
                     5'(`ACS_LEN_DIFF - 5'h01) : 5'(`ACS_LEN_NORMAL - 5'h01);
                  cur_nxt.shCnt = cur_r.chan[`ACS_CHAN_DIFF] ? `ACS_SH_DIFF : `ACS_SH_NORMAL;
               end
               else
               begin
                  // start bit cleared as the flag sets
                  cur_nxt.start = 1'b0;
                  cur_nxt.autoMode = 1'b0;
                  cur_nxt.state = acs_pkg::ST_IDLE;
               end
            end
         end
      endcase
      if (!cur_nxt.enable)
      begin
         cur_nxt.state = acs_pkg::ST_IDLE;
         cur_nxt.start = 1'b0;
         cur_nxt.restart = 1'b0;
         cur_nxt.shPulse = 1'b0;
         cur_nxt.autoMode = 1'b0;
      end
      // Hardware set wins over a software clear
      if (finish && cur_nxt.enable)
         cur_nxt.flag = 1'b1;
   end
   // State register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cur_r <= '0;
         cur_r.state <= acs_pkg::ST_IDLE;
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end
   // Checks
   sequence seqDone;
      cur_r.donePulse;
   endsequence
   sequence seqFreeDone;
      finish && freeRun && cur_nxt.enable;
   endsequence
   AST_START_DURING_CONV: assert property (@(posedge clk) disable iff (!reset_n)
      busy |-> cur_r.start) else $error("start bit low during conversion");
   AST_IDLE_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
      !cur_r.enable |-> cur_r.state == acs_pkg::ST_IDLE && !sampleHold)
      else $error("activity while disabled");
   AST_LOCK_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
      cur_r.locked && !(rdEn && paddr == `ACS_OFF_RESHI) |=> $stable(cur_r.result))
      else $error("result changed while locked");
   AST_FLAG_ON_DONE: assert property (@(posedge clk) disable iff (!reset_n)
      seqDone |-> cur_r.flag) else $error("flag not set at completion");
   // single mode clears start with completion
   AST_START_CLEARED: assert property (@(posedge clk) disable iff (!reset_n)
      finish && !freeRun |=> !cur_r.start && cur_r.donePulse)
      else $error("start not cleared at completion");
   // free running restarts immediately with start held
   AST_FREE_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
      seqFreeDone |=> busy && cur_r.start && cur_r.cnt == 5'h00)
      else $error("free running did not restart");
   AST_HOLD_FROZEN: assert property (@(posedge clk) disable iff (!reset_n)
      busy && $past(busy) && !$past(lastCycle) |-> $stable(cur_r.holdChan))
      else $error("selection changed during conversion");
   AST_PRESC_HELD: assert property (@(posedge clk) disable iff (!reset_n)
      !cur_r.enable |-> !ck.riseTick && !ck.fallTick)
      else $error("prescaler ran while disabled");
   // waiting start enters conversion on rising tick
   AST_START_ON_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
      cur_r.state == acs_pkg::ST_WAIT && ck.riseTick && cur_nxt.enable |=> busy)
      else $error("conversion did not begin on converter edge");
endmodule

/* File: tb/acs_core_model.sv */
// Purpose: Stand-in for the analog converter core
// Assumes: Result is built from applied reference and channel
// Notes: Output toggles while the core is off
`timescale 1ns/10ps
module acs_core_model (
   input wire logic clk, // CPU clock
   input wire logic coreEnable, // Analog enable
   input wire logic [5:0] coreChannel, // Applied channel
   input wire logic [1:0] coreReference, // Applied reference
   input wire logic sampleHold, // Sample pulse
   output logic [9:0] coreResult // Held result
);
   // Sample on the hold pulse; toggle when off so stale data never looks valid
   always @(posedge clk)
   begin
      if (!coreEnable)
         coreResult <= ~coreResult;
      else if (sampleHold)
         coreResult <= {coreReference, coreChannel, 2'h1};
   end
   initial coreResult = 10'h155;
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Prescaler select 0, converter clock is clk divided by 2
// Notes: Lengths are counted in CPU clocks
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] trigIn = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, coreEnable, sampleHold, convDone, completeFlag;
   logic [9:0] coreResult;
   logic [5:0] coreChannel;
   logic [1:0] coreReference;
   logic [31:0] rd;
   logic err;
   int failCount = 0;
   int checked = 0;
   int n, c;

   acs_sequencer #(.TRIG_WIDTH(8)) acs_sequencer_i (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
      .coreResult(coreResult), .coreEnable(coreEnable), .coreChannel(coreChannel),
      .coreReference(coreReference), .sampleHold(sampleHold), .convDone(convDone),
      .completeFlag(completeFlag));
   acs_core_model acs_core_model_i (.clk(clk), .coreEnable(coreEnable),
      .coreChannel(coreChannel), .coreReference(coreReference),
      .sampleHold(sampleHold), .coreResult(coreResult));

   // 250 MHz clock
   always #2 clk = ~clk;

   // One APB transfer, request held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No wait-state count assumed; the watchdog ends a hung transfer
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         failCount++;
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic rng(input string nm, input int lo, input int hi);
      checked++;
      if (n < lo || n > hi)
      begin
         $display("MISMATCH %s expected %0d to %0d seen %0d", nm, lo, hi, n);
         failCount++;
      end
   endtask

   // Bounded wait for the completion pulse, sampled mid-cycle
   task automatic wait_done();
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (convDone !== 1'b1 && n < 400);
      if (n >= 400)
         chk("completion", 32'h1, 32'h0);
   endtask

   task automatic count_done(input int cyc);
      c = 0;
      repeat (cyc)
      begin
         @(negedge clk);
         if (convDone === 1'b1)
            c++;
      end
   endtask

   // Clear flag, start, keep enabled
   task automatic conv();
      apb(1'b1, 8'h04, 32'hd0);
      wait_done();
   endtask

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog, far beyond the thousand or so cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      failCount++;
      complete_run();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      // Disabled converter, unmapped access
      rdchk(8'h04, 32'h0, "control reset");
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, 8'h00, 32'h45);
      apb(1'b1, 8'h04, 32'h40);
      count_done(100);
      chk("done while off", 32'h0, c);
      chk("channel while off", 32'h0, {26'h0, coreChannel});
      $display("Test disabled done");
      // First and normal conversions, right-justified result
      apb(1'b1, 8'h04, 32'hc0);
      wait_done();
      rng("first length", 48, 54);
      rdchk(8'h04, 32'h90, "control after done");
      rdchk(8'h0c, 32'h15, "low right");
      rdchk(8'h10, 32'h01, "high right");
      conv();
      rng("normal length", 24, 30);
      $display("Test lengths done");
      // Channel change mid-conversion waits for the end
      apb(1'b1, 8'h04, 32'hd0);
      apb(1'b1, 8'h00, 32'h87);
      chk("frozen channel", 32'h5, {26'h0, coreChannel});
      rdchk(8'h04, 32'hc0, "start while busy");
      wait_done();
      rdchk(8'h0c, 32'h15, "low old channel");
      rdchk(8'h10, 32'h01, "high old channel");
      // Low read locks both bytes, high read unlocks
      rdchk(8'h0c, 32'h15, "low before lock");
      conv();
      chk("flag while locked", 32'h1, {31'h0, completeFlag});
      rdchk(8'h10, 32'h01, "high locked");
      conv();
      rdchk(8'h0c, 32'h1d, "low unlocked");
      rdchk(8'h10, 32'h02, "high unlocked");
      $display("Test locking done");
      // Left adjust
      apb(1'b1, 8'h00, 32'h145);
      conv();
      rdchk(8'h0c, 32'h40, "low left");
      rdchk(8'h10, 32'h45, "high left");
      $display("Test left adjust done");
      // Auto trigger: edges during conversion and a held level start nothing
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h04, 32'hb0);
      @(posedge clk);
      trigIn <= 8'h02;
      repeat (6) @(posedge clk);
      trigIn <= 8'h00;
      repeat (6) @(posedge clk);
      trigIn <= 8'h02;
      count_done(200);
      chk("trigger conversions", 32'h1, c);
      @(posedge clk);
      trigIn <= 8'h00;
      @(posedge clk);
      trigIn <= 8'h02;
      wait_done();
      rng("auto length", 34, 34);
      $display("Test auto trigger done");
      // Free running, single-ended then differential
      apb(1'b1, 8'h08, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, 8'h04, 32'h0);
         apb(1'b1, 8'h00, i ? 32'h65 : 32'h45);
         apb(1'b1, 8'h04, 32'he0);
         wait_done();
         wait_done();
         rng("restart spacing", i ? 28 : 26, i ? 28 : 26);
         rdchk(8'h04, 32'hf0, "start free running");
      end
      // Leave free running, then one user-started differential conversion
      apb(1'b1, 8'h04, 32'h80);
      wait_done();
      conv();
      rng("diff length", 28, 31);
      $display("Test free running done");
      // Disable stops everything
      apb(1'b1, 8'h04, 32'h0);
      repeat (2) @(negedge clk);
      chk("enable off", 32'h0, {31'h0, coreEnable});
      chk("channel off", 32'h0, {26'h0, coreChannel});
      count_done(100);
      chk("done after off", 32'h0, c);
      $display("Test disable done");
      complete_run();
   end
endmodule
